// ==== hw/cantrx_pkg.sv ====
// Package for the transceiver mode and wake controller.
// Holds timing counts, register offsets, field positions and state codes.
package cantrx_pkg;
  localparam int unsigned CLK_HZ               = 40000000;
  // Transmit time-out of the transceiver in microseconds; the controller's reset limit keeps dominant runs below it.
  localparam int unsigned TXD_TIMEOUT_US       = 300;
  localparam int unsigned TXD_TIMEOUT_CYC      = (TXD_TIMEOUT_US * (CLK_HZ / 1000000));
  // Settle time after a normal request before the normal mode is entered, in microseconds.
  localparam int unsigned MODE_SETTLE_US       = 2;
  localparam int unsigned MODE_SETTLE_CYC      = (MODE_SETTLE_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W                = 16;

  // Register offsets (word index on the local port).
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_TXDATA = 4'h2;
  localparam logic [3:0] ADDR_LIMIT  = 4'h3;

  // Control register fields.
  localparam int unsigned CTRL_NORMAL_BIT  = 0;
  localparam int unsigned CTRL_AUTOWAKE_BIT = 1;
  localparam int unsigned CTRL_WAKECLR_BIT = 2;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;

  // Status register fields.
  localparam int unsigned STAT_NORMAL_BIT  = 0;
  localparam int unsigned STAT_WAKE_BIT    = 1;
  localparam int unsigned STAT_RX_BIT      = 2;
  localparam int unsigned STAT_CLAMP_BIT   = 3;
  localparam int unsigned STAT_TX_BIT      = 4;

  typedef enum logic [2:0] {
    CANTRX_STANDBY = 3'b001,
    CANTRX_SETTLE  = 3'b010,
    CANTRX_NORMAL  = 3'b100
  } cantrx_mode_t;
endpackage

// ==== hw/cantrx_sync.sv ====
// Two-stage synchroniser for a pin that comes from the transceiver.
// Assumes the pin may change at any time relative to clock_i.
`timescale 1ns/1ps
`default_nettype none
module cantrx_sync (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic din_i,
  output logic      dout_o
);
  logic stage1;

  // Resets high because the receive line rests recessive.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1 <= 1'b1;
      dout_o <= 1'b1;
    end else if (ce_i) begin
      stage1 <= din_i;
      dout_o <= stage1;
    end
  end
endmodule // cantrx_sync
`default_nettype wire

// ==== hw/cantrx_guard.sv ====
// Dominant run guard on the transmit path.
// Assumes limit_i is stable while transmitting; counts in clock_i cycles.
`timescale 1ns/1ps
`default_nettype none
module cantrx_guard (
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  input  wire logic                          tx_req_i,
  input  wire logic [cantrx_pkg::CNT_W-1:0]  limit_i,
  output logic                               tx_o,
  output logic                               clamp_o
);
  logic [cantrx_pkg::CNT_W-1:0] run;

  // A request of low is dominant; a forced recessive bit ends the run once it reaches limit_i.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run     <= '0;
      tx_o    <= 1'b1;
      clamp_o <= 1'b0;
    end else if (ce_i) begin
      if (tx_req_i) begin
        run     <= '0;
        tx_o    <= 1'b1;
        clamp_o <= 1'b0;
      end else if (run >= limit_i) begin
        tx_o    <= 1'b1;
        clamp_o <= 1'b1;
      end else begin
        run  <= run + 1'b1;
        tx_o <= 1'b0;
      end
    end
  end
endmodule // cantrx_guard
`default_nettype wire

// ==== hw/cantrx_ctrl.sv ====
// Controller that drives a CAN transceiver through its transmit, receive and mode pins.
// Assumes the transceiver pins are wired directly and rx arrives asynchronously.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cantrx_ctrl (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  // Software port.
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Protocol side.
  input  wire logic       tx_bit_i,
  output logic            rx_bit_o,
  output logic            wake_o,
  // Transceiver pins.
  input  wire logic       trx_rx_i,
  output logic            trx_tx_o,
  output logic            trx_standby_o
);
  cantrx_pkg::cantrx_mode_t mode;
  cantrx_pkg::cantrx_mode_t next_mode;

  logic                         rx_sync;
  logic                         rx_prev;
  logic                         ctrl_normal;
  logic                         ctrl_autowake;
  logic                         sw_tx;
  logic                         wake;
  logic                         tx_req;
  logic                         guard_tx;
  logic                         clamp;
  logic [cantrx_pkg::CNT_W-1:0] limit;
  logic [cantrx_pkg::CNT_W-1:0] settle;
  logic                         want_normal;
  logic                         wake_set;

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] target);
    is_reg = (a == target);
  endfunction

  cantrx_sync u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .din_i   (trx_rx_i),
    .dout_o  (rx_sync)
  );

  // The software data bit and the protocol bit are both needed recessive before the pin goes recessive.
  assign tx_req = (mode == cantrx_pkg::CANTRX_NORMAL) ? (tx_bit_i & sw_tx) : 1'b1;

  cantrx_guard u_guard (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .ce_i     (ce_i),
    .tx_req_i (tx_req),
    .limit_i  (limit),
    .tx_o     (guard_tx),
    .clamp_o  (clamp)
  );

  // Control registers.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_normal   <= cantrx_pkg::CTRL_RESET[cantrx_pkg::CTRL_NORMAL_BIT];
      ctrl_autowake <= cantrx_pkg::CTRL_RESET[cantrx_pkg::CTRL_AUTOWAKE_BIT];
      sw_tx         <= 1'b1;
      limit         <= cantrx_pkg::CNT_W'(cantrx_pkg::TXD_TIMEOUT_CYC - 1);
    end else if (ce_i) begin
      if (wr_i && is_reg(addr_i, cantrx_pkg::ADDR_CTRL)) begin
        ctrl_normal   <= wdata_i[cantrx_pkg::CTRL_NORMAL_BIT];
        ctrl_autowake <= wdata_i[cantrx_pkg::CTRL_AUTOWAKE_BIT];
      end else if (wake && ctrl_autowake && mode == cantrx_pkg::CANTRX_STANDBY) begin
        ctrl_normal <= 1'b1;
      end
      if (wr_i && is_reg(addr_i, cantrx_pkg::ADDR_TXDATA)) begin
        sw_tx <= wdata_i[0];
      end
      if (wr_i && is_reg(addr_i, cantrx_pkg::ADDR_LIMIT)) begin
        limit <= {limit[cantrx_pkg::CNT_W-1:8], wdata_i};
      end
    end
  end

  assign want_normal = ctrl_normal;

  // Mode sequencing.
  always_comb begin
    next_mode = mode;
    case (mode)
      cantrx_pkg::CANTRX_STANDBY: begin
        if (want_normal) begin
          next_mode = cantrx_pkg::CANTRX_SETTLE;
        end
      end
      cantrx_pkg::CANTRX_SETTLE: begin
        if (!want_normal) begin
          next_mode = cantrx_pkg::CANTRX_STANDBY;
        end else if (settle == '0) begin
          next_mode = cantrx_pkg::CANTRX_NORMAL;
        end
      end
      cantrx_pkg::CANTRX_NORMAL: begin
        if (!want_normal) begin
          next_mode = cantrx_pkg::CANTRX_STANDBY;
        end
      end
      default: next_mode = cantrx_pkg::CANTRX_STANDBY;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode   <= cantrx_pkg::CANTRX_STANDBY;
      settle <= '0;
    end else if (ce_i) begin
      mode <= next_mode;
      if (mode == cantrx_pkg::CANTRX_STANDBY) begin
        settle <= cantrx_pkg::CNT_W'(cantrx_pkg::MODE_SETTLE_CYC);
      end else if (settle != '0) begin
        settle <= settle - 1'b1;
      end
    end
  end

  // Pin drive: mode pin high only for standby, transmit held recessive outside normal.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trx_standby_o <= 1'b1;
      trx_tx_o      <= 1'b1;
    end else if (ce_i) begin
      trx_standby_o <= (next_mode == cantrx_pkg::CANTRX_STANDBY);
      // Leaving normal forces recessive at once, so a late dominant bit never meets a standby mode pin.
      trx_tx_o      <= (next_mode == cantrx_pkg::CANTRX_NORMAL) ? guard_tx : 1'b1;
    end
  end

  // Wake detection: a falling receive edge in standby means the transceiver has seen a filtered dominant.
  // A pin held low across a change into standby is not an edge, so a stuck bus gives no wake; out of reset a low pin is one, as rx_prev resets high.
  assign wake_set = (mode == cantrx_pkg::CANTRX_STANDBY) && rx_prev && !rx_sync;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_prev <= 1'b1;
      wake    <= 1'b0;
    end else if (ce_i) begin
      rx_prev <= rx_sync;
      if (wake_set) begin
        wake <= 1'b1;
      end else if (wr_i && is_reg(addr_i, cantrx_pkg::ADDR_CTRL) && wdata_i[cantrx_pkg::CTRL_WAKECLR_BIT]) begin
        wake <= 1'b0;
      end
    end
  end

  // Outputs to the protocol side and the software port.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_bit_o <= 1'b1;
      wake_o   <= 1'b0;
      rdata_o  <= 8'h00;
    end else if (ce_i) begin
      rx_bit_o <= (mode == cantrx_pkg::CANTRX_NORMAL) ? rx_sync : 1'b1;
      wake_o   <= wake;
      rdata_o  <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          cantrx_pkg::ADDR_CTRL: begin
            rdata_o <= {6'h00, ctrl_autowake, ctrl_normal};
          end
          cantrx_pkg::ADDR_STATUS: begin
            rdata_o <= {3'h0, ~guard_tx, clamp, rx_sync, wake, (mode == cantrx_pkg::CANTRX_NORMAL)};
          end
          cantrx_pkg::ADDR_TXDATA: begin
            rdata_o <= {7'h00, sw_tx};
          end
          cantrx_pkg::ADDR_LIMIT: begin
            rdata_o <= limit[7:0];
          end
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // cantrx_ctrl
`default_nettype wire

// ==== tb/cantrx_dev_model.sv ====
// Behavioural transceiver: mode pin, transmit guards, wake filter, split.
// Assumes the bench clock as time base; all counts are in its cycles.
`timescale 1ns/1ps
`default_nettype none
module cantrx_dev_model #(
  parameter int T_TO  = 11000,
  parameter int WAKE_DOMINANT_FILTER_TIME = 20,
  parameter int WAKE_RECESSIVE_FILTER_TIME = 20
) (
  input  wire logic clock_i,
  input  wire logic tx_i,
  input  wire logic stb_i,
  input  wire logic other_dom_i,
  input  wire logic hot_i,
  output logic      rx_o,
  output logic      bus_dom_o,
  output logic      split_on_o
);
  logic stby;
  logic to_off  = 1'b0;
  logic hot_off = 1'b0;
  logic tx_q    = 1'b1;
  logic armed   = 1'b0;
  logic woke    = 1'b0;
  logic wrx     = 1'b1;
  int   run     = 0;
  int   dcnt    = 0;
  int   rcnt    = 0;
  assign stby = (stb_i !== 1'b0);
  assign bus_dom_o = other_dom_i | (!stby & (tx_i === 1'b0) & !to_off & !hot_off);
  assign rx_o = stby ? (woke ? wrx : 1'b1) : !bus_dom_o;
  assign split_on_o = !stby;
  always @(posedge clock_i) begin
    tx_q <= tx_i;
    run <= (tx_i === 1'b0) ? run + 1 : 0;
    if (tx_i && !tx_q) to_off <= 1'b0;
    else if (run > T_TO) to_off <= 1'b1;
    if (hot_i) hot_off <= 1'b1;
    else if (tx_i && !tx_q) hot_off <= 1'b0;
    dcnt <= bus_dom_o ? dcnt + 1 : 0;
    rcnt <= bus_dom_o ? 0 : rcnt + 1;
    // Arming only after a recessive spell keeps a stuck bus from waking.
    armed <= stby & (armed | !bus_dom_o);
    if (!stby) woke <= 1'b0;
    else if (armed && dcnt > WAKE_DOMINANT_FILTER_TIME) woke <= 1'b1;
    if (dcnt > WAKE_DOMINANT_FILTER_TIME) wrx <= 1'b0;
    else if (rcnt > WAKE_RECESSIVE_FILTER_TIME) wrx <= 1'b1;
  end
endmodule // cantrx_dev_model
`default_nettype wire

// ==== tb/cantrx_ctrl_checker.sv ====
// Port checker for the transceiver controller, bound to it.
// Assumes a single clock domain and ce_i held high.
`timescale 1ns/1ps
`default_nettype none
module cantrx_ctrl_checker (
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       tx_bit_i,
  input wire logic       rx_bit_o,
  input wire logic       wake_o,
  input wire logic       trx_rx_i,
  input wire logic       trx_tx_o,
  input wire logic       trx_standby_o
);
  logic [15:0] dom_run;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) dom_run <= 16'h0000;
    else if (trx_tx_o) dom_run <= 16'h0000;
    else if (dom_run != 16'hFFFF) dom_run <= dom_run + 16'h0001;
  end
  a_normal_on_write: assert property (ce_i && wr_i && addr_i == cantrx_pkg::ADDR_CTRL && wdata_i[0]
    && trx_standby_o |-> ##2 !trx_standby_o)
    else $error("mode pin stayed high after a normal request");
  a_no_dom_standby: assert property (!trx_tx_o |-> !trx_standby_o)
    else $error("dominant transmit while in standby");
  a_dom_run_bound: assert property (dom_run <= cantrx_pkg::TXD_TIMEOUT_CYC + 2)
    else $error("dominant run exceeds the transmit time-out");
  a_wake_on_fall: assert property (trx_standby_o && $fell(trx_rx_i) |-> ##[1:5] wake_o)
    else $error("receive fall in standby did not raise wake");
  a_rx_high_stby: assert property (trx_standby_o && $past(trx_standby_o, 2) |-> rx_bit_o)
    else $error("receive bit not high in standby");
endmodule // cantrx_ctrl_checker
bind cantrx_ctrl cantrx_ctrl_checker cantrx_ctrl_checker_i (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_bit_i(tx_bit_i),
  .rx_bit_o(rx_bit_o), .wake_o(wake_o), .trx_rx_i(trx_rx_i), .trx_tx_o(trx_tx_o), .trx_standby_o(trx_standby_o));
`default_nettype wire

// ==== tb/cantrx_ctrl_tb.sv ====
// Bench for the transceiver controller against a behavioural transceiver.
// Assumes the model counts set below; runs about 12300 cycles.
`timescale 1ns/1ps
`default_nettype none
module cantrx_ctrl_tb;
  localparam int T_TO = 11000;
  localparam int T_WU = 20;
  // Only the low byte of the limit is writable, so the shortest limit keeps the upper bits.
  localparam int LIM  = (cantrx_pkg::TXD_TIMEOUT_CYC - 1) & 32'h0000FF00;
  logic       clock_i   = 1'b0;
  logic       rstn_i    = 1'b0;
  logic [3:0] addr_i    = 4'h0;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       tx_bit_i  = 1'b1;
  logic       other_dom = 1'b0;
  logic       hot       = 1'b0;
  logic       ce        = 1'b1;
  logic [7:0] rdata_o;
  logic       rx_bit_o, wake_o, trx_rx_i, trx_tx_o, trx_standby_o, bus_dom, split_on;
  int         n_errors    = 0;
  int         comparisons = 0;
  int         run;
  logic [3:0] rows [4] = '{4'hB, 4'h0, 4'hE, 4'h4};
  cantrx_ctrl cantrx_ctrl_i (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_bit_i(tx_bit_i), .rx_bit_o(rx_bit_o),
    .wake_o(wake_o), .trx_rx_i(trx_rx_i), .trx_tx_o(trx_tx_o), .trx_standby_o(trx_standby_o));
  cantrx_dev_model #(.T_TO(T_TO), .WAKE_DOMINANT_FILTER_TIME(T_WU), .WAKE_RECESSIVE_FILTER_TIME(T_WU)) cantrx_dev_model_i (.clock_i(clock_i),
    .tx_i(trx_tx_o), .stb_i(trx_standby_o), .other_dom_i(other_dom), .hot_i(hot), .rx_o(trx_rx_i),
    .bus_dom_o(bus_dom), .split_on_o(split_on));
  initial forever #12.5 clock_i = ~clock_i;
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk_byte(rdata_o, exp);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    wait_n(40000);
    n_errors++;
    report_and_stop();
  end
  initial begin
    wait_n(16);
    #1 chk_bit(trx_standby_o, 1'b1);
    chk_bit(trx_tx_o, 1'b1);
    @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(cantrx_pkg::ADDR_STATUS, 8'h04);
    rd(4'hF, 8'h00);
    $display("test reset done");
    // A normal request written while the clock enable is low must be lost.
    wait_n(1);
    ce <= 1'b0;
    wr(cantrx_pkg::ADDR_CTRL, 8'h01);
    ce <= 1'b1;
    wait_n(4);
    #1 chk_bit(trx_standby_o, 1'b1);
    rd(cantrx_pkg::ADDR_CTRL, 8'h00);
    $display("test clock enable done");
    wait_n(1);
    other_dom <= 1'b1;
    wait_n(T_WU / 2);
    other_dom <= 1'b0;
    wait_n(T_WU * 2);
    #1 chk_bit(wake_o, 1'b0);
    wait_n(1);
    other_dom <= 1'b1;
    wait_n(T_WU * 2);
    #1 chk_bit(wake_o, 1'b1);
    wait_n(1);
    other_dom <= 1'b0;
    wait_n(T_WU * 2);
    #1 chk_bit(trx_rx_i, 1'b1);
    wr(cantrx_pkg::ADDR_CTRL, 8'h04);
    rd(cantrx_pkg::ADDR_STATUS, 8'h04);
    $display("test wake done");
    wr(cantrx_pkg::ADDR_LIMIT, 8'h00);
    wr(cantrx_pkg::ADDR_CTRL, 8'h01);
    wait_n(100);
    #1 chk_bit(split_on, 1'b1);
    rd(cantrx_pkg::ADDR_STATUS, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wait_n(1);
      tx_bit_i <= rows[i][3];
      other_dom <= rows[i][2];
      wait_n(8);
      #1 chk_bit(trx_tx_o, rows[i][1]);
      chk_bit(rx_bit_o, rows[i][0]);
    end
    wait_n(1);
    tx_bit_i <= 1'b1;
    wr(cantrx_pkg::ADDR_TXDATA, 8'h00);
    wait_n(8);
    #1 chk_bit(trx_tx_o, 1'b0);
    rd(cantrx_pkg::ADDR_TXDATA, 8'h00);
    wr(cantrx_pkg::ADDR_TXDATA, 8'h01);
    tx_bit_i <= 1'b0;
    $display("test rows done");
    wait_n(1);
    other_dom <= 1'b0;
    hot <= 1'b1;
    wait_n(8);
    #1 chk_bit(rx_bit_o, 1'b1);
    wait_n(1);
    hot <= 1'b0;
    wait_n(8);
    #1 chk_bit(rx_bit_o, 1'b1);
    for (int k = 0; k < 2; k++) begin
      wait_n(1);
      tx_bit_i <= 1'b1;
      wait_n(4);
      tx_bit_i <= 1'b0;
      wait_n(8);
      #1 chk_bit(rx_bit_o, 1'b0);
      run = 0;
      while (k == 0 && trx_tx_o === 1'b0 && run < 20000) begin
        wait_n(1);
        #1 run++;
        if (run == T_TO) chk_bit(rx_bit_o, 1'b1);
      end
      if (k == 0) chk_bit(run >= LIM - 16 && run <= LIM + 2, 1'b1);
      if (k == 0) rd(cantrx_pkg::ADDR_STATUS, 8'h0D);
    end
    $display("test guards done");
    wait_n(1);
    tx_bit_i <= 1'b1;
    other_dom <= 1'b1;
    wait_n(8);
    wr(cantrx_pkg::ADDR_CTRL, 8'h02);
    wait_n(T_WU * 3);
    #1 chk_bit(wake_o, 1'b0);
    wait_n(1);
    other_dom <= 1'b0;
    wait_n(T_WU * 2);
    other_dom <= 1'b1;
    wait_n(T_WU * 3);
    #1 chk_bit(wake_o, 1'b1);
    chk_bit(trx_standby_o, 1'b0);
    $display("test dominant standby done");
    report_and_stop();
  end
endmodule // cantrx_ctrl_tb
`default_nettype wire
